// file: common/sarrd_pkg.sv
// package: constants and carrier types for the serial sar adc readout block
package sarrd_pkg;
  // ---------------------------------------------------------------
  // frame and result layout
  // ---------------------------------------------------------------
  localparam int RESULT_BITS = 14;
  localparam int LAST_EDGE = 16;
  localparam int MIN_VALID_EDGE = 14;
  localparam int NAP_PULSES = 2;
  localparam int SLEEP_PULSES = 4;
  localparam logic [4:0] EDGE_CNT_RESET = 5'h00;
  localparam logic [13:0] RESULT_RESET = 14'h0000;
  // ---------------------------------------------------------------
  // timing, in ns, and derived cycle counts at 100 mhz
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SELECT_RELEASE_AFTER_EDGE_TIME_NS = 5;
  localparam int NAP_WAKE_TIME_NS = 50;
  localparam int SLEEP_WAKE_TIME_NS = 1100000;
  localparam int NAP_WAKE_CYCLES = NAP_WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int SLEEP_WAKE_CYCLES = SLEEP_WAKE_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_NAP, PWR_SLEEP} sarrd_power_type;

  // pin view after synchronisation and edge finding
  typedef struct packed {
    logic sel_fall;
    logic sel_rise;
    logic sel_high;
    logic sck_fall;
    logic sck_rise;
    logic sck_level;
  } sarrd_pins_type;
endpackage

// file: hw/sarrd_edge.sv
// module: two-flop synchroniser with edge finder for one pin
`timescale 1ns/1ns
module sarrd_edge (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic pin_in, // raw asynchronous pin
  output logic level, // synchronised level
  output logic rise, // one-cycle pulse on rising edge
  output logic fall // one-cycle pulse on falling edge
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic last_reg, last_next;
  // ---------------------------------------------------------------
  // next values; the first flop feeds only the second
  // ---------------------------------------------------------------
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end
  // resets to high so an idle-high select gives no false edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end
  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule

// file: hw/sarrd_top.sv
// module: serial conversion and readout logic of a sampling sar adc
//
// Summary of operation
// R1 - result shifts out msb first to lsb
// R2 - frame shows previous frame's conversion result
// R3 - each sck fall advances conversion one step
// R4 - output bit changes only on sck fall
// R5 - works with burst or continuous sck
// R6 - select fall starts conversion, opens frame
// R7 - select high puts sample-hold into tracking
// R8 - output tristate while select high
// R9 - output released after sixteenth sck fall
// R10 - host keeps select low past fourteenth fall
// R11 - host meets acquisition and conversion times
// R12 - host keeps select high pulse wide enough
// R13 - host waits after nap wake
// R14 - host waits after sleep wake
// R15 - one or two leading zeros by idle level
// R16 - fourteen data bits then trailing zeros
// R17 - two select pulses nap, four sleep
// R18 - one sck pulse wakes device
// R19 - edge counter cleared at select fall
`timescale 1ns/1ns
module sarrd_top
  import sarrd_pkg::*;
#(
  parameter int WIDTH = RESULT_BITS, // result width
  parameter int SLEEP_WAKE = SLEEP_WAKE_CYCLES // sleep recovery in cycles
) (
  input wire logic mclk, // system clock, 100 mhz
  input wire logic rstn, // async reset, active low
  input wire logic frame_select_n, // frame select pin, active low
  input wire logic shift_clock_in, // shift clock pin
  input wire logic [WIDTH-1:0] sample_code, // comparator-side code of sampled input
  output logic serial_result_out_o, // serial data output value
  output logic serial_result_out_oe, // serial data output enable
  output logic tracking, // sample-and-hold in tracking mode
  output logic [WIDTH-1:0] conv_result, // last completed conversion
  output logic conv_valid, // one-cycle pulse when conversion completes
  output logic nap_mode, // device in nap
  output logic sleep_mode, // device in sleep
  output logic ready // converter usable (wake times elapsed)
);
  // elaboration checks: the frame word has room for at most fourteen result bits
  if (WIDTH < 1 || WIDTH > RESULT_BITS) begin : g_bad_width
    $error("width must be 1 to 14");
  end
  if (SLEEP_WAKE < 1) begin : g_bad_wake
    $error("sleep wake count must be positive");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  sarrd_pins_type pins;
  sarrd_edge u_sel (
    .mclk(mclk),
    .rstn(rstn),
    .pin_in(frame_select_n),
    .level(pins.sel_high),
    .rise(pins.sel_rise),
    .fall(pins.sel_fall)
  );
  sarrd_edge u_sck (
    .mclk(mclk),
    .rstn(rstn),
    .pin_in(shift_clock_in),
    .level(pins.sck_level),
    .rise(pins.sck_rise),
    .fall(pins.sck_fall)
  );

  // ---------------------------------------------------------------
  // frame state
  // ---------------------------------------------------------------
  logic [4:0] edge_cnt_reg, edge_cnt_next;
  logic [15:0] shift_reg, shift_next;
  logic [WIDTH-1:0] sar_reg, sar_next;
  logic [WIDTH-1:0] result_reg, result_next;
  logic sck_idle_reg, sck_idle_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic in_frame_reg, in_frame_next;
  logic valid_reg, valid_next;
  logic [WIDTH-1:0] trial;
  logic [WIDTH-1:0] step_bit;
  logic [15:0] load_word;

  // current sar bit under test, msb first
  always_comb begin
    step_bit = '0;
    // one trial per fall from the first, so every bit is settled by the fourteenth
    if (edge_cnt_reg < 5'(WIDTH)) begin
      step_bit[WIDTH - 1 - int'(edge_cnt_reg)] = 1'b1; // R3
    end
    trial = sar_reg | step_bit;
  end

  // frame word: leading zeros then result then trailing zeros
  always_comb begin
    load_word = '0;
    // sck high when select was last seen high gives two leading zeros, low gives one
    if (sck_idle_reg) begin
      load_word[15-2 -: WIDTH] = result_reg; // R15
    end else begin
      load_word[15-1 -: WIDTH] = result_reg; // R15
    end
  end

  always_comb begin
    edge_cnt_next = edge_cnt_reg;
    shift_next = shift_reg;
    sar_next = sar_reg;
    result_next = result_reg;
    sck_idle_next = sck_idle_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    in_frame_next = in_frame_reg;
    valid_next = 1'b0;
    if (pins.sel_high) begin
      sck_idle_next = pins.sck_level; // idle level seen during acquisition
    end
    if (pins.sel_fall && !nap_mode && !sleep_mode) begin
      // new frame: clear counter, load previous result, first leading zero
      edge_cnt_next = EDGE_CNT_RESET; // R19 R6
      shift_next = {load_word[14:0], 1'b0}; // R2
      sdo_next = load_word[15];
      oe_next = 1'b1; // R8
      in_frame_next = 1'b1;
      sar_next = '0;
    end else if (pins.sel_rise) begin
      // select high aborts any unfinished conversion, data is lost
      oe_next = 1'b0; // R8
      in_frame_next = 1'b0; // R7 R10
      sdo_next = 1'b0;
    end else if (in_frame_reg && pins.sck_fall) begin // R5
      // the counter saturates so long bursts keep giving zeros
      if (edge_cnt_reg != 5'd31) begin
        edge_cnt_next = edge_cnt_reg + 5'd1; // R19
      end
      sdo_next = shift_reg[15]; // R1 R4 R16
      shift_next = {shift_reg[14:0], 1'b0}; // R16
      if (step_bit != '0) begin
        // trial bit kept when comparator code says so
        sar_next = (sample_code >= trial) ? trial : sar_reg; // R3
      end
      if (edge_cnt_reg == 5'(MIN_VALID_EDGE - 1)) begin
        // fourteenth fall completes the conversion
        result_next = (sample_code >= trial) ? trial : sar_reg; // R2 R3
        valid_next = 1'b1;
      end
      if (edge_cnt_reg == 5'(LAST_EDGE - 1)) begin
        oe_next = 1'b0; // R9
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      edge_cnt_reg <= EDGE_CNT_RESET;
      shift_reg <= 16'h0000;
      sar_reg <= '0;
      result_reg <= '0;
      sck_idle_reg <= 1'b1;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      in_frame_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
      shift_reg <= shift_next;
      sar_reg <= sar_next;
      result_reg <= result_next;
      sck_idle_reg <= sck_idle_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      in_frame_reg <= in_frame_next;
      valid_reg <= valid_next;
    end
  end

  // ---------------------------------------------------------------
  // nap and sleep control
  // ---------------------------------------------------------------
  sarrd_power_type pwr_reg, pwr_next;
  logic [2:0] pulse_cnt_reg, pulse_cnt_next;
  logic [31:0] wake_cnt_reg, wake_cnt_next;
  logic track_reg, track_next;
  logic moved_reg, moved_next;

  // select pulses with sck static count toward power-down; any sck edge resets while active, only an sck rise once in nap or sleep
  always_comb begin
    pwr_next = pwr_reg;
    pulse_cnt_next = pulse_cnt_reg;
    wake_cnt_next = wake_cnt_reg;
    moved_next = moved_reg;
    track_next = pins.sel_high; // R7
    // note any shift clock edge since the last select fall
    if (pins.sel_fall) begin
      moved_next = pins.sck_fall | pins.sck_rise;
    end else if (pins.sck_fall || pins.sck_rise) begin
      moved_next = 1'b1;
    end
    if (wake_cnt_reg != 32'd0) begin
      wake_cnt_next = wake_cnt_reg - 32'd1; // R13 R14
    end
    if (pwr_reg != PWR_ACTIVE) begin
      track_next = 1'b0;
      if (pins.sck_rise) begin
        // one sck pulse wakes from either mode
        pwr_next = PWR_ACTIVE; // R18
        pulse_cnt_next = 3'd0;
        wake_cnt_next = (pwr_reg == PWR_SLEEP) ? 32'(SLEEP_WAKE)
                                               : 32'(NAP_WAKE_CYCLES); // R14 R13
      end else if (pins.sel_rise && pulse_cnt_reg < 3'(SLEEP_PULSES)) begin
        pulse_cnt_next = pulse_cnt_reg + 3'd1;
        if (pulse_cnt_reg + 3'd1 == 3'(SLEEP_PULSES)) begin
          pwr_next = PWR_SLEEP; // R17
        end
      end
    end else if (pins.sck_fall || pins.sck_rise) begin
      pulse_cnt_next = 3'd0; // clocked frames never power down
    end else if (pins.sel_rise && moved_reg) begin
      // a frame that carried shift clock edges is no power-down pulse
      pulse_cnt_next = 3'd0; // R17
    end else if (pins.sel_rise) begin
      pulse_cnt_next = pulse_cnt_reg + 3'd1;
      if (pulse_cnt_reg + 3'd1 == 3'(NAP_PULSES)) begin
        pwr_next = PWR_NAP; // R17
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwr_reg <= PWR_ACTIVE;
      pulse_cnt_reg <= 3'd0;
      wake_cnt_reg <= 32'd0;
      track_reg <= 1'b1;
      moved_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      pulse_cnt_reg <= pulse_cnt_next;
      wake_cnt_reg <= wake_cnt_next;
      track_reg <= track_next;
      moved_reg <= moved_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  logic nap_reg, sleep_reg, ready_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nap_reg <= 1'b0;
      sleep_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      nap_reg <= (pwr_next == PWR_NAP);
      sleep_reg <= (pwr_next == PWR_SLEEP);
      ready_reg <= (pwr_next == PWR_ACTIVE) && (wake_cnt_next == 32'd0);
    end
  end
  assign nap_mode = nap_reg;
  assign sleep_mode = sleep_reg;
  assign ready = ready_reg;
  assign serial_result_out_o = sdo_reg;
  assign serial_result_out_oe = oe_reg;
  assign tracking = track_reg;
  assign conv_result = result_reg;
  assign conv_valid = valid_reg;
endmodule

// file: tb/sarrd_sva.sv
// checker: pin timing relations of the serial readout block
`timescale 1ns/1ns
module sarrd_sva
  import sarrd_pkg::*;
#(
  parameter int WIDTH = RESULT_BITS, // result width
  parameter int SLEEP_WAKE = SLEEP_WAKE_CYCLES // sleep recovery cycles
) (
  input wire logic mclk, // clock
  input wire logic rstn, // reset, active low
  input wire logic frame_select_n, // select pin
  input wire logic shift_clock_in, // shift clock pin
  input wire logic [WIDTH-1:0] sample_code, // sampled code
  input wire logic serial_result_out_o, // data bit
  input wire logic serial_result_out_oe, // data enable
  input wire logic tracking, // tracking flag
  input wire logic [WIDTH-1:0] conv_result, // result
  input wire logic conv_valid, // completion pulse
  input wire logic nap_mode, // nap flag
  input wire logic sleep_mode, // sleep flag
  input wire logic ready // usable flag
);
  logic sck_reg, sck_next;
  logic [4:0] cnt_reg, cnt_next;
  // count raw shift clock falls in a frame; saturates so long bursts never wrap
  always_comb begin
    sck_next = shift_clock_in;
    cnt_next = cnt_reg;
    if (frame_select_n) begin
      cnt_next = 5'h00;
    end else if (sck_reg && !shift_clock_in && cnt_reg != 5'h1f) begin
      cnt_next = cnt_reg + 5'h01;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_reg <= 1'b1;
      cnt_reg <= 5'h00;
    end else begin
      sck_reg <= sck_next;
      cnt_reg <= cnt_next;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // windows of 6 cycles cover the synchroniser plus output register
  a_oe_select_high: assert property (frame_select_n [*6] |-> !serial_result_out_oe)
    else $error("data enabled with select high");
  a_first_bit_zero: assert property ($rose(serial_result_out_oe) |-> !serial_result_out_o)
    else $error("first bit of frame not zero");
  a_bit_on_fall: assert property ((shift_clock_in [*6] ##0 serial_result_out_oe
    && $past(serial_result_out_oe)) |-> $stable(serial_result_out_o))
    else $error("data bit moved without clock fall");
  a_release_sixteen: assert property ((cnt_reg >= 5'd16) [*6] |-> !serial_result_out_oe)
    else $error("data still enabled after last fall");
  a_valid_count: assert property (conv_valid |-> cnt_reg == 5'd14)
    else $error("completion not at fourteenth fall");
  a_result_code: assert property (conv_valid |=> conv_result == sample_code)
    else $error("completed result differs from code");
  a_track_frame: assert property ((!frame_select_n) [*6] |-> !tracking)
    else $error("tracking inside a frame");
  a_low_power: assert property ((nap_mode || sleep_mode) |-> !ready)
    else $error("ready while powered down");
  a_sleep_wake: assert property ($fell(sleep_mode) |-> !ready [*8] ##[1:40] ready)
    else $error("sleep recovery time wrong");
  a_nap_wake: assert property (($fell(nap_mode) && !sleep_mode) |-> !ready [*4] ##[1:4] ready)
    else $error("nap recovery time wrong");
endmodule
bind sarrd_top sarrd_sva #(.WIDTH(WIDTH), .SLEEP_WAKE(SLEEP_WAKE)) u_sarrd_sva (.mclk, .rstn,
  .frame_select_n, .shift_clock_in, .sample_code, .serial_result_out_o, .serial_result_out_oe,
  .tracking, .conv_result, .conv_valid, .nap_mode, .sleep_mode, .ready);

// file: tb/sarrd_host.sv
// partner: host controller driving select and shift clock, capturing words
`timescale 1ns/1ns
module sarrd_host (
  input wire logic sdo_line, // resolved data line
  output logic frame_select_n, // select, active low
  output logic shift_clock_in, // shift clock, 125 ns
  output logic [15:0] word, // captured frame word
  output logic word_done // pulse per frame
);
  initial begin
    frame_select_n = 1'b1;
    shift_clock_in = 1'b1;
    word = 16'h0000;
    word_done = 1'b0;
  end
  // sample each bit just before the fall that replaces it; clock stands between frames
  task automatic frame(input logic idle_hi, input int falls);
    word = 16'h0000;
    shift_clock_in = idle_hi;
    #100;
    frame_select_n = 1'b0;
    for (int i = 0; i < falls; i++) begin
      shift_clock_in = 1'b1;
      #62;
      if (i < 16) word[15-i] = sdo_line;
      shift_clock_in = 1'b0;
      #63;
    end
    #20;
    frame_select_n = 1'b1;
    shift_clock_in = idle_hi;
    #60;
    word_done = 1'b1;
    #10;
    word_done = 1'b0;
  endtask
  // select pulses with the shift clock static
  task automatic pulses(input int n);
    repeat (n) begin
      #50;
      frame_select_n = 1'b0;
      #50;
      frame_select_n = 1'b1;
    end
  endtask
  task automatic wake();
    shift_clock_in = ~shift_clock_in;
    #62;
    shift_clock_in = ~shift_clock_in;
  endtask
endmodule

// file: tb/sarrd_top_tb_top.sv
// testbench: frames, abort, nap and sleep for the serial readout block
`timescale 1ns/1ns
module sarrd_top_tb_top;
  import sarrd_pkg::*;
  localparam int SW = 20; // short sleep recovery keeps the run brief
  logic mclk, rstn, sel_n, sck, sdo_line, o, oe, word_done;
  logic tracking, conv_valid, nap_mode, sleep_mode, ready;
  logic [13:0] sample_code, conv_result, prev;
  logic [15:0] word;
  logic [15:0] exp_q[$];
  int mismatches, checks, seed;
  // a released line floats, so case equality catches an early release
  assign sdo_line = oe ? o : 1'bz;
  sarrd_top #(.SLEEP_WAKE(SW)) u_sarrd_top (.mclk(mclk), .rstn(rstn), .frame_select_n(sel_n),
    .shift_clock_in(sck), .sample_code(sample_code), .serial_result_out_o(o),
    .serial_result_out_oe(oe), .tracking(tracking), .conv_result(conv_result),
    .conv_valid(conv_valid), .nap_mode(nap_mode), .sleep_mode(sleep_mode), .ready(ready));
  sarrd_host u_sarrd_host (.sdo_line(sdo_line), .frame_select_n(sel_n), .shift_clock_in(sck),
    .word(word), .word_done(word_done));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // each captured word is judged against the oldest noted expectation
  always @(posedge word_done) begin
    chk("word", word, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
  end
  // one frame with a fresh random code; an aborted frame keeps the old result
  task automatic run(input logic hi, input int falls);
    logic [15:0] e;
    @(posedge mclk);
    #1 sample_code = 14'($random(seed));
    e = hi ? {2'b00, prev} : {1'b0, prev, 1'b0};
    exp_q.push_back(falls < 16 ? e & (16'hffff << (16 - falls)) : e);
    u_sarrd_host.frame(hi, falls);
    if (falls >= 14) prev = sample_code;
    chk("result", {2'b00, conv_result}, {2'b00, prev});
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk("ready", {15'h0000, ready}, 16'h0001);
    if (n == 100) close_out();
  endtask
  initial begin
    rstn = 1'b0;
    sample_code = 14'h0000;
    prev = RESULT_RESET;
    seed = 62;
    checks = 0;
    mismatches = 0;
    repeat (2) @(posedge mclk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 6; i++) run(i[0], 16 + (i % 3));
    run(1'b1, 10);
    chk("track", {15'h0000, tracking}, 16'h0001);
    run(1'b0, 16);
    u_sarrd_host.pulses(2);
    repeat (6) @(posedge mclk);
    chk("nap", {15'h0000, nap_mode}, 16'h0001);
    u_sarrd_host.wake();
    wait_ready();
    run(1'b1, 16);
    u_sarrd_host.pulses(4);
    repeat (6) @(posedge mclk);
    chk("sleep", {15'h0000, sleep_mode}, 16'h0001);
    u_sarrd_host.wake();
    wait_ready();
    run(1'b0, 16);
    run(1'b1, 16);
    close_out();
  end
endmodule
